// file: src/run_permit_pkg.sv
// package: register map, field layout, reset values, timing and state codes of the run-permit block
package run_permit_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;            // core_clk at 20 mhz
  localparam int unsigned TICK_TIME_NS = 100_000_000;    // delay settings count 0.1 s steps
  localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] DELAY_MAX = 16'h8ca0;          // 3600.0 s in 0.1 s steps

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WAKE_OFS = 8'h04;
  localparam logic [7:0] RWAIT_OFS = 8'h08;
  localparam logic [7:0] LOWER_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // ----------------------------------------------------------------
  // control and status field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PROTECT_BIT = 0;
  localparam int unsigned ACTION_LSB = 1;
  localparam int unsigned RESTART_BIT = 3;
  localparam int unsigned INIT_DONE_BIT = 4;
  localparam int unsigned STAT_TERM_BIT = 8;
  localparam int unsigned STAT_CNT_LSB = 16;
  localparam logic PROTECT_RST = 1'b0;
  localparam logic [1:0] ACTION_RST = 2'h0;
  localparam logic RESTART_RST = 1'b0;
  localparam logic [15:0] WAKE_RST = 16'h0000;            // 0.0 s
  localparam logic [15:0] RWAIT_RST = 16'h000a;           // 1.0 s
  localparam logic [15:0] LOWER_RST = 16'h0000;

  // lower-limit action codes
  localparam logic [1:0] ACT_CLAMP = 2'h0;
  localparam logic [1:0] ACT_STOP = 2'h1;
  localparam logic [1:0] ACT_SLEEP = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_INIT = 7'b0000001,
    ST_IDLE = 7'b0000010,
    ST_PROTECT = 7'b0000100,
    ST_RWAIT = 7'b0001000,
    ST_RUN = 7'b0010000,
    ST_HALT = 7'b0100000,
    ST_SLEEP = 7'b1000000
  } run_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic init_done;
    logic power_cut_restart_sel;
    logic [1:0] below_lower_limit_action_sel;
    logic power_on_terminal_protect_sel;
  } cfg_t;

endpackage : run_permit_pkg

// file: src/run_permit_sleep_wake_control.sv
// run-permission, lower-limit sleep/stop and power-cut restart controller with apb registers
//
// Decided for this implementation: the address map and the APB interface to the registers.

module run_permit_sleep_wake_control #(
  parameter int unsigned TICK_LEN = run_permit_pkg::TICK_CYCLES  // cycles per 0.1 s step
) (
  input wire logic core_clk,                        // system clock, 20 mhz
  input wire logic reset,                           // async reset, active high
  input wire run_permit_pkg::apb_req_t apb_req,     // apb request from master
  output logic [31:0] prdata,                       // apb read data
  output logic pready,                              // apb ready
  output logic pslverr,                             // apb error, unmapped or read-only
  input wire logic run_term,                        // run command terminal, high = run
  input wire logic power_cut_run,                   // drive was running when power was cut
  input wire logic [15:0] set_freq,                 // set frequency, 0.01 hz
  input wire logic [15:0] run_freq,                 // running frequency, 0.01 hz
  output logic drive_run,                           // drive permitted to run
  output logic clamp_active,                        // running held at lower limit
  output logic coast_stop,                          // coasting after stop action
  output logic sleep_active,                        // asleep after sleep action
  output logic protect_active                       // power-on run protection held
);
  import run_permit_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] clamp_delay(input logic [31:0] wd);
    clamp_delay = (wd[15:0] > DELAY_MAX || wd[31:16] != 16'h0000) ? DELAY_MAX : wd[15:0];
  endfunction : clamp_delay

  function automatic logic freq_above(input logic [15:0] f, input logic [15:0] lim);
    freq_above = f > lim;
  endfunction : freq_above

  // ----------------------------------------------------------------
  // register group
  // ----------------------------------------------------------------
  cfg_t cfg_r, cfg_nxt;
  logic [15:0] wake_r, wake_nxt;
  logic [15:0] rwait_r, rwait_nxt;
  logic [15:0] lower_r, lower_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  run_state_t state_r, state_nxt;
  logic [15:0] dly_r, dly_nxt;
  logic [31:0] div_r, div_nxt;
  logic term_pw_r, term_pw_nxt;
  logic access, mapped, ro_hit;

  assign access = apb_req.psel && apb_req.penable && pready_r;
  assign ro_hit = apb_req.paddr == STATUS_OFS;
  assign mapped = apb_req.paddr == CTRL_OFS || apb_req.paddr == WAKE_OFS ||
                  apb_req.paddr == RWAIT_OFS || apb_req.paddr == LOWER_OFS || ro_hit;

  // bus slave: answer one cycle after setup, writes land at the access edge
  always_comb
  begin
    cfg_nxt = cfg_r;
    wake_nxt = wake_r;
    rwait_nxt = rwait_r;
    lower_nxt = lower_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    pready_nxt = apb_req.psel && !apb_req.penable;
    if (apb_req.psel && !apb_req.penable)
    begin
      pslverr_nxt = !mapped || (apb_req.pwrite && ro_hit);
      prdata_nxt = 32'h0000_0000;
      if (!apb_req.pwrite)
      begin
        case (apb_req.paddr)
          CTRL_OFS: prdata_nxt = {27'h0000000, cfg_r};
          WAKE_OFS: prdata_nxt = {16'h0000, wake_r};
          RWAIT_OFS: prdata_nxt = {16'h0000, rwait_r};
          LOWER_OFS: prdata_nxt = {16'h0000, lower_r};
          STATUS_OFS: prdata_nxt = {dly_r, 7'h00, term_pw_r, 1'b0, state_r};
          default: prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (access && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        CTRL_OFS:
        begin
          cfg_nxt.power_on_terminal_protect_sel = apb_req.pwdata[PROTECT_BIT];
          cfg_nxt.power_cut_restart_sel = apb_req.pwdata[RESTART_BIT];
          // code 3 is undefined, so such a write keeps the old action
          if (apb_req.pwdata[ACTION_LSB +: 2] != 2'h3)
            cfg_nxt.below_lower_limit_action_sel = apb_req.pwdata[ACTION_LSB +: 2];
          // init_done only sets; power-up ends once
          cfg_nxt.init_done = cfg_r.init_done | apb_req.pwdata[INIT_DONE_BIT];
        end
        WAKE_OFS: wake_nxt = clamp_delay(apb_req.pwdata);
        RWAIT_OFS: rwait_nxt = clamp_delay(apb_req.pwdata);
        LOWER_OFS: lower_nxt = apb_req.pwdata[15:0];
        default: lower_nxt = lower_r;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_r <= '{init_done: 1'b0, power_cut_restart_sel: RESTART_RST,
                 below_lower_limit_action_sel: ACTION_RST,
                 power_on_terminal_protect_sel: PROTECT_RST};
      wake_r <= WAKE_RST;
      rwait_r <= RWAIT_RST;
      lower_r <= LOWER_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      wake_r <= wake_nxt;
      rwait_r <= rwait_nxt;
      lower_r <= lower_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // run control state machine
  // ----------------------------------------------------------------
  logic tick, set_above, set_below, run_below, restart_go, start_ok, wake_due;
  logic clamp_nxt, run_nxt, coast_nxt, sleep_nxt, prot_nxt;
  logic drive_run_r, clamp_r, coast_r, sleep_r, prot_r;

  assign tick = div_r == TICK_LEN - 1;
  assign set_above = freq_above(set_freq, lower_r);
  assign set_below = freq_above(lower_r, set_freq);
  assign run_below = freq_above(lower_r, run_freq);
  assign restart_go = cfg_r.power_cut_restart_sel && power_cut_run;
  assign start_ok = !set_below || cfg_r.below_lower_limit_action_sel == ACT_CLAMP;
  assign wake_due = dly_r >= wake_r;

  // a divider restarted on every state change keeps each delay to within one tick
  always_comb
  begin
    state_nxt = state_r;
    dly_nxt = dly_r;
    div_nxt = tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
    term_pw_nxt = term_pw_r;
    case (state_r)
      ST_INIT:
      begin
        term_pw_nxt = run_term;
        if (cfg_r.init_done)
        begin
          if (restart_go)
            state_nxt = ST_RWAIT;
          else if (term_pw_r && cfg_r.power_on_terminal_protect_sel)
            state_nxt = ST_RUN;
          else if (term_pw_r)
            state_nxt = ST_PROTECT;
          else
            state_nxt = ST_IDLE;
        end
      end
      ST_IDLE:
        if (run_term && start_ok)
          state_nxt = ST_RUN;
      ST_PROTECT:
        if (!run_term)
          state_nxt = ST_IDLE;
      ST_RWAIT:
        if (dly_r >= rwait_r)
          state_nxt = start_ok ? ST_RUN : ST_IDLE;
        else if (tick)
          dly_nxt = dly_r + 16'h0001;
      ST_RUN:
        if (!run_term)
          state_nxt = ST_IDLE;
        else if (cfg_r.below_lower_limit_action_sel == ACT_STOP && set_below)
          state_nxt = ST_HALT;
        else if (cfg_r.below_lower_limit_action_sel == ACT_SLEEP && run_below)
          state_nxt = ST_SLEEP;
      ST_HALT, ST_SLEEP:
        if (!run_term)
          state_nxt = ST_IDLE;
        else if (!set_above)
        begin
          dly_nxt = 16'h0000;
          div_nxt = 32'h0000_0000;
        end
        else if (wake_due)
          state_nxt = ST_RUN;
        else if (tick)
          dly_nxt = dly_r + 16'h0001;
      default:
        state_nxt = ST_INIT;
    endcase
    if (state_nxt != state_r)
    begin
      dly_nxt = 16'h0000;
      div_nxt = 32'h0000_0000;
    end
    run_nxt = state_nxt == ST_RUN;
    clamp_nxt = run_nxt && cfg_r.below_lower_limit_action_sel == ACT_CLAMP && set_below;
    coast_nxt = state_nxt == ST_HALT;
    sleep_nxt = state_nxt == ST_SLEEP;
    prot_nxt = state_nxt == ST_PROTECT;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= ST_INIT;
      dly_r <= 16'h0000;
      div_r <= 32'h0000_0000;
      term_pw_r <= 1'b0;
      drive_run_r <= 1'b0;
      clamp_r <= 1'b0;
      coast_r <= 1'b0;
      sleep_r <= 1'b0;
      prot_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      dly_r <= dly_nxt;
      div_r <= div_nxt;
      term_pw_r <= term_pw_nxt;
      drive_run_r <= run_nxt;
      clamp_r <= clamp_nxt;
      coast_r <= coast_nxt;
      sleep_r <= sleep_nxt;
      prot_r <= prot_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign drive_run = drive_run_r;
  assign clamp_active = clamp_r;
  assign coast_stop = coast_r;
  assign sleep_active = sleep_r;
  assign protect_active = prot_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  init_no_run_a: assert property (state_r == ST_INIT |-> !drive_run_r)
    else $error("drive runs before power-up finished");
  protect_entry_a: assert property (state_r == ST_INIT && cfg_r.init_done && !restart_go &&
    term_pw_r && !cfg_r.power_on_terminal_protect_sel |=> prot_r && !drive_run_r)
    else $error("held terminal at power-up did not enter protection");
  protect_hold_a: assert property (prot_r && run_term |=> !drive_run_r)
    else $error("drive started without terminal release");
  auto_start_a: assert property (state_r == ST_INIT && cfg_r.init_done && !restart_go &&
    term_pw_r && cfg_r.power_on_terminal_protect_sel |=> drive_run_r)
    else $error("held terminal at power-up did not auto start");
  clamp_flag_a: assert property (state_r == ST_RUN && run_term && set_below &&
    cfg_r.below_lower_limit_action_sel == ACT_CLAMP |=> drive_run_r && clamp_r)
    else $error("clamp action did not keep running at lower limit");
  coast_entry_a: assert property (state_r == ST_RUN && run_term && set_below &&
    cfg_r.below_lower_limit_action_sel == ACT_STOP |=> coast_r && !drive_run_r)
    else $error("stop action did not coast");
  sleep_entry_a: assert property (state_r == ST_RUN && run_term && run_below &&
    cfg_r.below_lower_limit_action_sel == ACT_SLEEP && !set_below |=> sleep_r)
    else $error("sleep action did not sleep");
  wake_time_a: assert property ($rose(drive_run_r) && ($past(coast_r) || $past(sleep_r))
    |-> $past(dly_r) >= $past(wake_r))
    else $error("woke before wake delay elapsed");
  wake_restart_a: assert property ((coast_r || sleep_r) && run_term && !set_above
    |=> dly_r == 16'h0000 && !drive_run_r)
    else $error("wake count not cleared on drop below limit");
  restart_off_a: assert property (state_r == ST_INIT && cfg_r.init_done &&
    !cfg_r.power_cut_restart_sel |=> state_r != ST_RWAIT)
    else $error("restart wait entered while restart disabled");
  restart_wait_a: assert property (state_r == ST_RWAIT && dly_r < rwait_r |=> !drive_run_r)
    else $error("restart ran before wait time");
  delay_range_a: assert property (wake_r <= DELAY_MAX && rwait_r <= DELAY_MAX)
    else $error("delay setting out of range");

endmodule : run_permit_sleep_wake_control

// file: verification/run_permit_sleep_wake_control_bench.sv
// bench: apb-driven scenarios for the run-permit block
module run_permit_sleep_wake_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import run_permit_pkg::*;

  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  localparam int unsigned TL = 4; // short tick keeps delays to a few cycles
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  apb_req_t apb_req = '0;
  logic run_term = 1'b1;
  logic power_cut_run = 1'b0;
  logic [15:0] set_freq = 16'h07d0;
  logic [15:0] run_freq = 16'h07d0;
  logic [31:0] prdata;
  logic pready, pslverr, drive_run, clamp_active, coast_stop, sleep_active, protect_active;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int checks = 0;

  run_permit_sleep_wake_control #(.TICK_LEN(TL)) i_dut (
    .core_clk(core_clk), .reset(reset), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .run_term(run_term),
    .power_cut_run(power_cut_run), .set_freq(set_freq), .run_freq(run_freq),
    .drive_run(drive_run), .clamp_active(clamp_active), .coast_stop(coast_stop),
    .sleep_active(sleep_active), .protect_active(protect_active)
  );

  // clock at 50 ns
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // one apb transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 20)
      failures++;
    rd = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    xfer(1'b1, a, d);
    cmp_bit("write pslverr", e, er);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic ee);
    xfer(1'b0, a, 32'h0);
    cmp_word("read data", e, rd & m);
    cmp_bit("read pslverr", ee, er);
  endtask : rdc

  // bounded wait: a hung state machine shows up as a mismatch, not a hang
  task automatic wait_run(input logic e, input int lim);
    int n;
    n = 0;
    while (drive_run !== e && n < lim)
    begin
      n++;
      @(posedge core_clk);
    end
    cmp_bit("drive_run", e, drive_run);
  endtask : wait_run

  task automatic do_reset();
    reset <= 1'b1;
    cyc(6);
    reset <= 1'b0;
  endtask : do_reset

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    cyc(20000);
    failures++;
    conclude();
  end

  // ------------------------------------------------
  // tests
  // ------------------------------------------------
  initial
  begin
    cyc(6);
    reset <= 1'b0;
    rdc(CTRL_OFS, 32'h0, 32'hffffffff, 1'b0);
    rdc(WAKE_OFS, 32'h0, 32'hffffffff, 1'b0);
    rdc(RWAIT_OFS, 32'ha, 32'hffffffff, 1'b0);
    rdc(STATUS_OFS, 32'h1, 32'h7f, 1'b0);
    rdc(8'h14, 32'h0, 32'hffffffff, 1'b1);
    wr(STATUS_OFS, 32'h0, 1'b1);
    wr(WAKE_OFS, 32'hffff, 1'b0);
    rdc(WAKE_OFS, 32'h8ca0, 32'hffffffff, 1'b0);
    wr(WAKE_OFS, 32'h0, 1'b0);
    cmp_bit("drive_run", 1'b0, drive_run);
    // terminal held through power-up with protection on
    wr(CTRL_OFS, 32'h10, 1'b0);
    cyc(3);
    cmp_bit("protect_active", 1'b1, protect_active);
    cmp_bit("drive_run", 1'b0, drive_run);
    rdc(STATUS_OFS, 32'h104, 32'h17f, 1'b0);
    run_term <= 1'b0;
    cyc(3);
    cmp_bit("protect_active", 1'b0, protect_active);
    cmp_bit("drive_run", 1'b0, drive_run);
    run_term <= 1'b1;
    wait_run(1'b1, 10);
    // clamp at lower limit
    wr(LOWER_OFS, 32'h3e8, 1'b0);
    set_freq <= 16'h01f4;
    cyc(3);
    cmp_bit("clamp_active", 1'b1, clamp_active);
    cmp_bit("drive_run", 1'b1, drive_run);
    // stop action, wake delay of four ticks, interrupted once
    wr(WAKE_OFS, 32'h4, 1'b0);
    wr(CTRL_OFS, 32'h12, 1'b0);
    cyc(3);
    cmp_bit("coast_stop", 1'b1, coast_stop);
    cmp_bit("drive_run", 1'b0, drive_run);
    rdc(STATUS_OFS, 32'h20, 32'h7f, 1'b0);
    set_freq <= 16'h07d0;
    cyc(8);
    set_freq <= 16'h01f4;
    cyc(2);
    set_freq <= 16'h07d0;
    cyc(8);
    cmp_bit("drive_run", 1'b0, drive_run);
    wait_run(1'b1, 40);
    cyc(2);
    cmp_bit("coast_stop", 1'b0, coast_stop);
    // sleep action with zero wake delay; code 3 must not replace the action
    wr(WAKE_OFS, 32'h0, 1'b0);
    wr(CTRL_OFS, 32'h14, 1'b0);
    // running frequency drops first so sleep entry is seen with the set frequency still high
    run_freq <= 16'h01f4;
    cyc(1);
    set_freq <= 16'h01f4;
    cyc(3);
    cmp_bit("sleep_active", 1'b1, sleep_active);
    cmp_bit("drive_run", 1'b0, drive_run);
    rdc(STATUS_OFS, 32'h40, 32'h7f, 1'b0);
    wr(CTRL_OFS, 32'h16, 1'b0);
    rdc(CTRL_OFS, 32'h14, 32'h1f, 1'b0);
    set_freq <= 16'h07d0;
    run_freq <= 16'h07d0;
    wait_run(1'b1, 10);
    run_term <= 1'b0;
    wait_run(1'b0, 10);
    // protection off: held terminal starts after init; restart disabled
    run_term <= 1'b1;
    power_cut_run <= 1'b1;
    do_reset();
    wr(CTRL_OFS, 32'h11, 1'b0);
    wait_run(1'b1, 10);
    cmp_bit("protect_active", 1'b0, protect_active);
    // restart after power cut with a four-tick wait
    run_term <= 1'b0;
    do_reset();
    wr(RWAIT_OFS, 32'h4, 1'b0);
    wr(CTRL_OFS, 32'h18, 1'b0);
    rdc(STATUS_OFS, 32'h8, 32'h7f, 1'b0);
    cmp_bit("drive_run", 1'b0, drive_run);
    wait_run(1'b1, 40);
    conclude();
  end

endmodule : run_permit_sleep_wake_control_bench
